// ---- hdl/cml_top.sv ----
// Capacity model lookup engine with application parameters and aging
`timescale 1ns/10ps
`default_nettype none
module cml_top #(
  parameter int UPDATE_CYCLES = cml_pkg::UPDATE_CYCLES,
  parameter int SAVE_EVERY    = cml_pkg::SAVE_EVERY
) (
  // Clock and reset
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  // Register port
  input  wire logic [7:0]        i_reg_addr,
  input  wire logic              i_reg_wr,
  input  wire logic              i_reg_rd,
  input  wire logic [7:0]        i_reg_wdata,
  output logic      [7:0]        o_reg_rdata,
  // Measurements
  input  wire logic signed [7:0] i_temp_c,
  input  wire logic [7:0]        i_voltage_reading,
  input  wire logic              i_voltage_reading_stb,
  input  wire logic signed [15:0] i_current_reading,
  input  wire logic              i_cur_stb,
  input  wire logic signed [15:0] i_average_current_reading,
  input  wire logic              i_avg_stb,
  input  wire logic              i_acr_dec,
  // Nonvolatile store
  input  wire logic              i_nv_restore,
  input  wire logic [7:0]        i_nv_as,
  output logic                   o_nv_save,
  output logic      [7:0]        o_nv_as,
  // Results and flags
  output logic      [15:0]       o_full_t,
  output logic      [15:0]       o_ae_t,
  output logic      [15:0]       o_se_t,
  output logic      [15:0]       o_full_mah,
  output logic      [7:0]        o_age_scale_factor,
  output logic                   o_charged_full_flag,
  output logic                   o_learn_cycle_flag,
  output logic                   o_busy
);

  typedef struct packed {
    cml_pkg::cml_fsm_t  st;
    logic [1:0]         curve;
    logic [1:0]         seg;
    logic [19:0]        acc;
    logic signed [7:0]  temp;
    logic [31:0]        tick;
    logic [15:0]        full_t;
    logic [15:0]        ae_t;
    logic [15:0]        se_t;
    logic [15:0]        full_mah;
    logic [7:0]         bp_upper;
    logic [7:0]         bp_lower;
    logic [7:0]         sense;
    logic [7:0]         charge_voltage_threshold;
    logic [7:0]         min_charge_current;
    logic [7:0]         empty_voltage_threshold;
    logic [7:0]         empty_current_threshold;
    logic [7:0]         as_f;
    logic [7:0]         ae50;
    logic [15:0]        ac;
    logic [15:0]        full50;
    logic               chgf;
    logic               learn_cycle_flag;
    logic               voltage_reading_hi;
    logic               avg_ok;
    logic               cur_big1;
    logic               cur_big2;
    logic [20:0]        age_cnt;
    logic [7:0]         save_cnt;
    logic               nv_save;
    logic [7:0]         nv_as;
    logic [7:0]         rdata;
    logic               rsel;
  } cml_regs_t;

  localparam logic [31:0] TICK_LAST = 32'(UPDATE_CYCLES - 1);
  localparam logic [7:0]  SAVE_LAST = 8'(SAVE_EVERY - 1);

  cml_regs_t q;
  cml_regs_t d;

  cml_mem_if #(.AW(cml_pkg::SLOPE_AW), .DW(8)) mem ();

  cml_slope_mem #(
    .DEPTH (cml_pkg::SLOPE_DEPTH),
    .AW    (cml_pkg::SLOPE_AW),
    .DW    (8)
  ) u_slope_mem (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .bus       (mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Degrees that one segment covers between t and +50C

  function automatic logic [8:0] seg_deg(input logic signed [7:0] t,
                                         input logic [1:0] s,
                                         input logic signed [7:0] bp_up,
                                         input logic signed [7:0] bp_lo);
    logic signed [9:0] hi;
    logic signed [9:0] lo;
    logic signed [9:0] m;
    logic signed [9:0] dd;
    case (s)
      2'd3: begin
        hi = cml_pkg::T_HOT;
        lo = cml_pkg::T_MID;
      end
      2'd2: begin
        hi = cml_pkg::T_MID;
        lo = 10'(bp_up);
      end
      2'd1: begin
        hi = 10'(bp_up);
        lo = 10'(bp_lo);
      end
      default: begin
        hi = 10'(bp_lo);
        lo = cml_pkg::T_COLD_LIM;
      end
    endcase
    m  = (10'(t) > lo) ? 10'(t) : lo;
    dd = hi - m;
    return (dd > 10'sh000) ? dd[8:0] : 9'h000;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  logic [8:0]  deg;
  logic [16:0] prod;
  logic [19:0] base;
  logic [19:0] val;
  logic [31:0] p_mvh;
  logic [25:0] p_aged;
  logic [26:0] p_mah;
  logic        in_slope;
  logic        full_qual;
  logic        full_det;
  logic        cur_big;
  logic        empty_det;
  logic        age_evt;
  logic        learn_up;

  always_comb begin
    d         = q;
    d.nv_save = 1'b0;
    deg       = seg_deg(q.temp, q.seg, q.bp_upper, q.bp_lower);
    prod      = 17'(mem.rdata_b * deg);
    base      = '0;
    val       = '0;
    p_mvh     = '0;
    p_aged    = '0;
    p_mah     = '0;
    in_slope  = (i_reg_addr >= cml_pkg::ADDR_SLOPE_LO) &&
                (i_reg_addr <= cml_pkg::ADDR_SLOPE_HI);

    // Slope table access
    mem.we      = i_reg_wr && in_slope;
    mem.waddr   = 4'(i_reg_addr - cml_pkg::ADDR_SLOPE_LO);
    mem.wdata   = i_reg_wdata;
    mem.raddr_a = 4'(i_reg_addr - cml_pkg::ADDR_SLOPE_LO);
    mem.raddr_b = 4'({q.curve, q.seg});

    // Update interval
    d.tick = (q.tick == TICK_LAST) ? 32'h0000_0000 : q.tick + 32'h0000_0001;

    // Lookup sequencer
    case (q.st)
      cml_pkg::CML_IDLE: begin
        if (q.tick == TICK_LAST) begin
          d.temp  = i_temp_c;
          d.curve = 2'd0;
          d.seg   = 2'd0;
          d.acc   = '0;
          d.st    = cml_pkg::CML_READ;
        end
      end
      cml_pkg::CML_READ: begin
        d.st = cml_pkg::CML_ACC;
      end
      cml_pkg::CML_ACC: begin
        d.acc = q.acc + 20'(prod);
        if (q.seg == 2'(cml_pkg::NUM_SEGS - 1)) begin
          d.st = cml_pkg::CML_STORE;
        end else begin
          d.seg = q.seg + 2'd1;
          d.st  = cml_pkg::CML_READ;
        end
      end
      cml_pkg::CML_STORE: begin
        case (q.curve)
          2'd0:    base = cml_pkg::FULL_BASE;
          2'd1:    base = 20'({q.ae50, 6'h00});
          default: base = '0;
        endcase
        val = (base > q.acc) ? base - q.acc : '0;
        case (q.curve)
          2'd0: begin
            d.full_t = 16'(val);
            p_mvh    = q.full50 * 16'(val);
            p_aged   = 26'((p_mvh >> cml_pkg::FRAC_SHIFT) * q.as_f);
            p_mah    = 27'((p_aged >> cml_pkg::AS_SHIFT) * q.sense);
            d.full_mah = (p_mah > 27'h000ffff) ? 16'hffff : 16'(p_mah);
          end
          2'd1:    d.ae_t = 16'(val);
          default: d.se_t = 16'(val);
        endcase
        if (q.curve == 2'(cml_pkg::NUM_CURVES - 1)) begin
          d.st = cml_pkg::CML_IDLE;
          d.save_cnt = (q.save_cnt == SAVE_LAST) ? 8'h00 : q.save_cnt + 8'h01;
          if (q.save_cnt == SAVE_LAST && q.as_f != q.nv_as) begin
            d.nv_save = 1'b1;
            d.nv_as   = q.as_f;
          end
        end else begin
          d.curve = q.curve + 2'd1;
          d.seg   = 2'd0;
          d.acc   = '0;
          d.st    = cml_pkg::CML_READ;
        end
      end
      default: d.st = cml_pkg::CML_IDLE;
    endcase

    // Full detection
    full_qual = (i_average_current_reading > 16'sh0000) &&
                (i_average_current_reading <
                 16'({q.min_charge_current, 5'h00}));
    full_det  = i_avg_stb && full_qual && q.avg_ok && q.voltage_reading_hi;
    if (i_voltage_reading_stb && (i_voltage_reading <= q.charge_voltage_threshold)) begin
      d.voltage_reading_hi = 1'b0;
    end
    if (i_avg_stb) begin
      d.avg_ok  = full_qual;
      d.voltage_reading_hi = i_voltage_reading > q.charge_voltage_threshold;
    end

    // Active empty detection
    cur_big   = i_current_reading < -(17'sd0 + 17'($signed({1'b0, q.empty_current_threshold, 7'h00})));
    empty_det = i_voltage_reading_stb && (i_voltage_reading < q.empty_voltage_threshold) &&
                q.cur_big1 && q.cur_big2;
    if (i_cur_stb) begin
      d.cur_big2 = q.cur_big1;
      d.cur_big1 = cur_big;
    end
    if (empty_det) begin
      d.chgf = 1'b0;
    end
    if (full_det) begin
      d.learn_cycle_flag = 1'b0;
    end
    if (empty_det) begin
      d.learn_cycle_flag = 1'b1;
    end
    if (full_det) begin
      d.chgf = 1'b1;
    end

    // Aging counter
    age_evt = 1'b0;
    if (i_acr_dec) begin
      if (21'(q.age_cnt + 21'h000001) >= {q.ac, 5'h00}) begin
        d.age_cnt = '0;
        age_evt   = 1'b1;
      end else begin
        d.age_cnt = q.age_cnt + 21'h000001;
      end
    end

    // Age scalar sources, host write highest
    learn_up = full_det && q.learn_cycle_flag;
    if (age_evt && q.as_f > cml_pkg::AS_MIN) begin
      d.as_f = q.as_f - 8'h01;
    end
    if (learn_up && q.as_f < cml_pkg::AS_UNAGED) begin
      d.as_f = q.as_f + 8'h01;
    end
    if (i_nv_restore) begin
      d.as_f  = i_nv_as;
      d.nv_as = i_nv_as;
    end

    // Register writes
    if (i_reg_wr) begin
      case (i_reg_addr)
        cml_pkg::ADDR_CHARGE_VOLTAGE_THRESHOLD:     d.charge_voltage_threshold     = i_reg_wdata;
        cml_pkg::ADDR_MIN_CHARGE_CURRENT:     d.min_charge_current     = i_reg_wdata;
        cml_pkg::ADDR_VAE:      d.empty_voltage_threshold      = i_reg_wdata;
        cml_pkg::ADDR_IAE:      d.empty_current_threshold      = i_reg_wdata;
        cml_pkg::ADDR_AS:       d.as_f     = i_reg_wdata;
        cml_pkg::ADDR_SENSE:    d.sense    = i_reg_wdata;
        cml_pkg::ADDR_FULL50_H: d.full50   = {i_reg_wdata, q.full50[7:0]};
        cml_pkg::ADDR_FULL50_L: d.full50   = {q.full50[15:8], i_reg_wdata};
        cml_pkg::ADDR_AE50:     d.ae50     = i_reg_wdata;
        cml_pkg::ADDR_AC_H:     d.ac       = {i_reg_wdata, q.ac[7:0]};
        cml_pkg::ADDR_AC_L:     d.ac       = {q.ac[15:8], i_reg_wdata};
        cml_pkg::ADDR_BP_UPPER: d.bp_upper = i_reg_wdata;
        cml_pkg::ADDR_BP_LOWER: d.bp_lower = i_reg_wdata;
        default: ;
      endcase
    end

    // Register reads, one cycle latency
    d.rsel = i_reg_rd && in_slope;
    d.rdata = 8'h00;
    if (i_reg_rd) begin
      case (i_reg_addr)
        cml_pkg::ADDR_CHARGE_VOLTAGE_THRESHOLD:     d.rdata = q.charge_voltage_threshold;
        cml_pkg::ADDR_MIN_CHARGE_CURRENT:     d.rdata = q.min_charge_current;
        cml_pkg::ADDR_VAE:      d.rdata = q.empty_voltage_threshold;
        cml_pkg::ADDR_IAE:      d.rdata = q.empty_current_threshold;
        cml_pkg::ADDR_AS:       d.rdata = q.as_f;
        cml_pkg::ADDR_SENSE:    d.rdata = q.sense;
        cml_pkg::ADDR_FULL50_H: d.rdata = q.full50[15:8];
        cml_pkg::ADDR_FULL50_L: d.rdata = q.full50[7:0];
        cml_pkg::ADDR_AE50:     d.rdata = q.ae50;
        cml_pkg::ADDR_AC_H:     d.rdata = q.ac[15:8];
        cml_pkg::ADDR_AC_L:     d.rdata = q.ac[7:0];
        cml_pkg::ADDR_BP_UPPER: d.rdata = q.bp_upper;
        cml_pkg::ADDR_BP_LOWER: d.rdata = q.bp_lower;
        cml_pkg::ADDR_FULLT_H:  d.rdata = q.full_t[15:8];
        cml_pkg::ADDR_FULLT_L:  d.rdata = q.full_t[7:0];
        cml_pkg::ADDR_AET_H:    d.rdata = q.ae_t[15:8];
        cml_pkg::ADDR_AET_L:    d.rdata = q.ae_t[7:0];
        cml_pkg::ADDR_SET_H:    d.rdata = q.se_t[15:8];
        cml_pkg::ADDR_SET_L:    d.rdata = q.se_t[7:0];
        cml_pkg::ADDR_FMAH_H:   d.rdata = q.full_mah[15:8];
        cml_pkg::ADDR_FMAH_L:   d.rdata = q.full_mah[7:0];
        cml_pkg::ADDR_STATUS: begin
          d.rdata[cml_pkg::ST_CHGF]  = q.chgf;
          d.rdata[cml_pkg::ST_LEARN] = q.learn_cycle_flag;
          d.rdata[cml_pkg::ST_BUSY]  = q.st != cml_pkg::CML_IDLE;
        end
        default: d.rdata = 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      q          <= '0;
      q.st       <= cml_pkg::CML_IDLE;
      q.as_f     <= cml_pkg::AS_UNAGED;
      q.nv_as    <= cml_pkg::AS_UNAGED;
      q.charge_voltage_threshold     <= cml_pkg::PARAM_RST;
      q.full50   <= cml_pkg::WORD_RST;
      q.ac       <= cml_pkg::WORD_RST;
      q.full_t   <= 16'(cml_pkg::FULL_BASE);
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign o_reg_rdata         = q.rsel ? mem.rdata_a : q.rdata;
  assign o_nv_save           = q.nv_save;
  assign o_nv_as             = q.nv_as;
  assign o_full_t            = q.full_t;
  assign o_ae_t              = q.ae_t;
  assign o_se_t              = q.se_t;
  assign o_full_mah          = q.full_mah;
  assign o_age_scale_factor  = q.as_f;
  assign o_charged_full_flag = q.chgf;
  assign o_learn_cycle_flag  = q.learn_cycle_flag;
  assign o_busy              = q.st != cml_pkg::CML_IDLE;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  a_hot_full_flat: assert property (
    (q.st == cml_pkg::CML_STORE && q.curve == 2'd0 && 10'(q.temp) >= cml_pkg::T_HOT)
    |=> q.full_t == 16'(cml_pkg::FULL_BASE)) else $error("full curve not flat when hot");
  a_four_segments: assert property (
    (q.st == cml_pkg::CML_IDLE && q.tick == TICK_LAST)
    |=> (q.st == cml_pkg::CML_READ) [*1] ##8 (q.st == cml_pkg::CML_STORE))
    else $error("segment walk length wrong");
  a_temp_held: assert property (
    (q.st != cml_pkg::CML_IDLE && $past(q.st) != cml_pkg::CML_IDLE) |-> $stable(q.temp))
    else $error("temperature moved mid lookup");
  a_standby_hot: assert property (
    (q.st == cml_pkg::CML_STORE && q.curve == 2'd2 && 10'(q.temp) >= cml_pkg::T_HOT)
    |=> q.se_t == 16'h0000) else $error("standby not zero when hot");
  a_tick_start: assert property (
    (q.tick == TICK_LAST && q.st == cml_pkg::CML_IDLE) |=> q.st == cml_pkg::CML_READ ##2
    q.st == cml_pkg::CML_READ) else $error("update not started");
  a_full_sets: assert property (
    (full_det && !empty_det) |=> q.chgf && !q.learn_cycle_flag) else $error("full detect lost");
  a_empty_sets: assert property (
    (empty_det && !full_det) |=> q.learn_cycle_flag && !q.chgf) else $error("empty detect lost");
  a_age_step: assert property (
    (age_evt && q.as_f > cml_pkg::AS_MIN && !learn_up && !i_nv_restore && !i_reg_wr)
    |=> q.as_f == $past(q.as_f) - 8'h01) else $error("age scalar not decremented");
  a_restore_as: assert property (
    (i_nv_restore && !(i_reg_wr && i_reg_addr == cml_pkg::ADDR_AS))
    |=> q.as_f == $past(i_nv_as)) else $error("age scalar not restored");
  a_save_data: assert property (
    o_nv_save |-> o_nv_as == $past(q.as_f)) else $error("saved value mismatch");

  c_lookup_done: cover property (q.st == cml_pkg::CML_STORE && q.curve == 2'd2);
  c_full_seen:   cover property (full_det);
  c_empty_seen:  cover property (empty_det);
  c_age_step:    cover property (age_evt);

endmodule
`default_nettype wire

// ---- pkg/cml_pkg.sv ----
// Shared constants and types for the capacity model lookup block
package cml_pkg;

  typedef enum logic [1:0] {CML_IDLE, CML_READ, CML_ACC, CML_STORE} cml_fsm_t;

  // Time base
  localparam int CLK_MHZ          = 125;
  localparam int UPDATE_PERIOD_US = 3515000;
  localparam int UPDATE_CYCLES    = UPDATE_PERIOD_US * CLK_MHZ;
  localparam int SAVE_EVERY       = 8;

  // Model shape
  localparam int NUM_CURVES  = 3;
  localparam int NUM_SEGS    = 4;
  localparam int SLOPE_DEPTH = NUM_CURVES * NUM_SEGS;
  localparam int SLOPE_AW    = 4;

  // Register map (byte offsets on the serial register port)
  localparam logic [7:0] ADDR_CHARGE_VOLTAGE_THRESHOLD      = 8'h64;
  localparam logic [7:0] ADDR_MIN_CHARGE_CURRENT      = 8'h65;
  localparam logic [7:0] ADDR_VAE       = 8'h66;
  localparam logic [7:0] ADDR_IAE       = 8'h67;
  localparam logic [7:0] ADDR_AS        = 8'h68;
  localparam logic [7:0] ADDR_SENSE     = 8'h69;
  localparam logic [7:0] ADDR_SLOPE_LO  = 8'h6b;
  localparam logic [7:0] ADDR_FULL_S3   = 8'h6d;
  localparam logic [7:0] ADDR_SLOPE_HI  = 8'h76;
  localparam logic [7:0] ADDR_FULL50_H  = 8'h77;
  localparam logic [7:0] ADDR_FULL50_L  = 8'h78;
  localparam logic [7:0] ADDR_AE50      = 8'h79;
  localparam logic [7:0] ADDR_AC_H      = 8'h7a;
  localparam logic [7:0] ADDR_AC_L      = 8'h7b;
  localparam logic [7:0] ADDR_BP_UPPER  = 8'h7c;
  localparam logic [7:0] ADDR_BP_LOWER  = 8'h7d;
  localparam logic [7:0] ADDR_FULLT_H   = 8'h80;
  localparam logic [7:0] ADDR_FULLT_L   = 8'h81;
  localparam logic [7:0] ADDR_AET_H     = 8'h82;
  localparam logic [7:0] ADDR_AET_L     = 8'h83;
  localparam logic [7:0] ADDR_SET_H     = 8'h84;
  localparam logic [7:0] ADDR_SET_L     = 8'h85;
  localparam logic [7:0] ADDR_FMAH_H    = 8'h86;
  localparam logic [7:0] ADDR_FMAH_L    = 8'h87;
  localparam logic [7:0] ADDR_STATUS    = 8'h88;

  // Status bit positions
  localparam int ST_CHGF  = 0;
  localparam int ST_LEARN = 1;
  localparam int ST_BUSY  = 2;

  // Temperature corners, whole degrees, 10-bit signed
  localparam logic signed [9:0] T_HOT      = 10'sh032;
  localparam logic signed [9:0] T_MID      = 10'sh019;
  localparam logic signed [9:0] T_COLD_LIM = 10'sh200;

  // Fixed point: 2^-14 of the +50C full value per LSB
  localparam int         FRAC_SHIFT = 14;
  localparam logic [19:0] FULL_BASE = 20'h04000;
  localparam int         AE50_SHIFT = 6;

  // Age scale: 2^-7 per LSB
  localparam int         AS_SHIFT   = 7;
  localparam logic [7:0] AS_UNAGED  = 8'h80;
  localparam logic [7:0] AS_MIN     = 8'h3f;
  localparam int         AGE_SHIFT  = 5;

  // Current thresholds against 1.5625uV current LSB
  localparam int MIN_CHARGE_CURRENT_SHIFT = 5;
  localparam int IAE_SHIFT  = 7;

  // Reset values of host parameters
  localparam logic [7:0]  PARAM_RST  = 8'h00;
  localparam logic [15:0] WORD_RST   = 16'h0000;

endpackage

// ---- pkg/cml_mem_if.sv ----
// Port bundle between the model engine and its slope memory
`timescale 1ns/10ps
`default_nettype none
interface cml_mem_if #(
  parameter int AW = 4,
  parameter int DW = 8
);
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr_a;
  logic [DW-1:0] rdata_a;
  logic [AW-1:0] raddr_b;
  logic [DW-1:0] rdata_b;

  modport mem  (input we, waddr, wdata, raddr_a, raddr_b, output rdata_a, rdata_b);
  modport user (output we, waddr, wdata, raddr_a, raddr_b, input rdata_a, rdata_b);
endinterface
`default_nettype wire

// ---- hdl/cml_slope_mem.sv ----
// Slope table: one write port, two registered read ports
`timescale 1ns/10ps
`default_nettype none
module cml_slope_mem #(
  parameter int DEPTH = 12,
  parameter int AW    = 4,
  parameter int DW    = 8
) (
  // Clock and reset
  input  wire logic i_clk_sys,
  input  wire logic i_rst,
  // Memory ports
  cml_mem_if.mem    bus
);

  logic [DW-1:0] mem_q [DEPTH];
  logic [DW-1:0] rda_q;
  logic [DW-1:0] rdb_q;

  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      rda_q <= '0;
      rdb_q <= '0;
    end else begin
      if (bus.we && (int'(bus.waddr) < DEPTH)) begin
        mem_q[bus.waddr] <= bus.wdata;
      end
      rda_q <= (int'(bus.raddr_a) < DEPTH) ? mem_q[bus.raddr_a] : '0;
      rdb_q <= (int'(bus.raddr_b) < DEPTH) ? mem_q[bus.raddr_b] : '0;
    end
  end

  assign bus.rdata_a = rda_q;
  assign bus.rdata_b = rdb_q;

endmodule
`default_nettype wire

// ---- bench/cml_host_model.sv ----
// Host model: byte writes and reads on the register port
`timescale 1ns/10ps
`default_nettype none
module cml_host_model (
  // Register port
  input  wire logic       i_clk_sys,
  output logic      [7:0] o_addr,
  output logic            o_wr,
  output logic            o_rd,
  output logic      [7:0] o_wdata,
  input  wire logic [7:0] i_rdata
);
  initial {o_addr, o_wr, o_rd, o_wdata} = 18'h0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    {o_addr, o_wdata, o_wr} <= {a, d, 1'b1};
    @(posedge i_clk_sys);
    o_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    {o_addr, o_rd} <= {a, 1'b1};
    @(posedge i_clk_sys);
    o_rd <= 1'b0;
    #1 d = i_rdata;
  endtask
  // Pack build: age scale near 95 percent
  task automatic new_pack;
    wr(8'h68, 8'h7a);
  endtask
endmodule
`default_nettype wire

// ---- bench/capacity_model_lookup_test.sv ----
// Self-checking bench for the capacity model lookup block
`timescale 1ns/10ps
`default_nettype none
module capacity_model_lookup_test;
  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic        [7:0] addr, wdata, rdata, voltage_reading, nv_in, rv, age, nv_out;
  logic              wr, rd, voltage_reading_stb, cur_stb, avg_stb, acr_dec, nv_rst;
  logic              nv_save, chg, learn, busy;
  logic signed [7:0] temp = 8'sh32;
  logic       [15:0] cur, avg, full_t, ae_t, se_t, mah;
  int                fail_count = 0;
  int                cmp_count = 0;
  int                saves = 0;
  logic        [7:0] sl[12] = '{8'h08, 8'h09, 8'h1a, 8'h2c, 8'h0e, 8'h19,
                                8'h2c, 8'h33, 8'h04, 8'h03, 8'h0f, 8'h04};
  logic        [7:0] ra[12] = '{8'h64, 8'h65, 8'h66, 8'h67, 8'h69, 8'h77,
                                8'h78, 8'h79, 8'h7a, 8'h7b, 8'h7c, 8'h7d};
  logic        [7:0] wd[12] = '{8'hd8, 8'h10, 8'ha0, 8'h01, 8'h05, 8'h00,
                                8'h10, 8'h40, 8'h00, 8'h01, 8'h00, 8'hf4};
  logic signed [7:0] tr[9] = '{8'h3c, 8'h32, 8'h25, 8'h19, 8'h03,
                               8'h00, 8'hfb, 8'hf4, 8'hd8};

  always #4 clk_sys = ~clk_sys;
  // Count save pulses seen at the NV side
  always @(posedge clk_sys) begin
    if (nv_save === 1'b1) saves++;
  end

  cml_top #(.UPDATE_CYCLES(40), .SAVE_EVERY(2)) u_cml_top (
    .i_clk_sys(clk_sys), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_temp_c(temp),
    .i_voltage_reading(voltage_reading), .i_voltage_reading_stb(voltage_reading_stb), .i_current_reading(cur),
    .i_cur_stb(cur_stb), .i_average_current_reading(avg), .i_avg_stb(avg_stb),
    .i_acr_dec(acr_dec), .i_nv_restore(nv_rst), .i_nv_as(nv_in),
    .o_nv_save(nv_save), .o_nv_as(nv_out), .o_full_t(full_t), .o_ae_t(ae_t),
    .o_se_t(se_t), .o_full_mah(mah), .o_age_scale_factor(age),
    .o_charged_full_flag(chg), .o_learn_cycle_flag(learn), .o_busy(busy));
  cml_host_model u_cml_host_model (
    .i_clk_sys(clk_sys), .o_addr(addr), .o_wr(wr), .o_rd(rd),
    .o_wdata(wdata), .i_rdata(rdata));

  ////////////////////////////////////////////////////////////////////////////
  // Base less each slope times the degrees its segment covers
  function automatic logic [15:0] curve(input int c, input int b, input int t);
    int hi[5] = '{50, 25, 0, -12, -200};
    int v;
    v = b;
    for (int s = 4; s >= 1; s--) begin
      v -= int'(sl[c*4+s-1]) * ((t >= hi[4-s]) ? 0 :
           (t > hi[5-s]) ? hi[4-s] - t : hi[4-s] - hi[5-s]);
    end
    return (v < 0) ? 16'h0 : 16'(v);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("Compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic wrd(input logic [7:0] a, input logic [7:0] d);
    u_cml_host_model.wr(a, d);
    u_cml_host_model.rd(a, rv);
  endtask
  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy !== lvl) begin
      @(negedge clk_sys);
      n++;
      if (n > 100) begin
        fail_count++;
        report_and_stop();
      end
    end
  endtask
  task automatic lookup(input logic signed [7:0] t);
    @(posedge clk_sys);
    temp <= t;
    repeat (2) begin
      wait_busy(1'b1);
      wait_busy(1'b0);
    end
  endtask
  // k: 0 voltage, 1 current, 2 average, 3 accumulator step, 4 recall
  task automatic stb(input int k, input logic [15:0] v);
    @(posedge clk_sys);
    {nv_rst, acr_dec, avg_stb, cur_stb, voltage_reading_stb} <= 5'b1 << k;
    if (k == 0) voltage_reading <= v[7:0];
    if (k == 1) cur <= v;
    if (k == 2) avg <= v;
    if (k == 4) nv_in <= v[7:0];
    @(posedge clk_sys);
    {nv_rst, acr_dec, avg_stb, cur_stb, voltage_reading_stb} <= 5'h0;
    repeat (2) @(negedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {nv_rst, acr_dec, avg_stb, cur_stb, voltage_reading_stb, voltage_reading, nv_in} = 21'h0;
    {cur, avg} = 32'h0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk(full_t, 16'h4000);
    chk({age, nv_out}, 16'h8080);
    for (int i = 0; i < 12; i++) begin
      wrd(ra[i], wd[i]);
      chk({8'h0, rv}, {8'h0, wd[i]});
    end
    for (int i = 0; i < 12; i++) begin
      wrd(8'h6b + 8'(i), sl[i]);
      chk({8'h0, rv}, {8'h0, sl[i]});
    end
    u_cml_host_model.new_pack();
    @(negedge clk_sys);
    chk({8'h0, age}, 16'h007a);
    $display("Test registers done");
    for (int i = 0; i < 9; i++) begin
      lookup(tr[i]);
      chk(full_t, curve(0, 16'h4000, tr[i]));
      chk(ae_t, curve(1, 16'h1000, tr[i]));
      chk(se_t, curve(2, 16'h0000, tr[i]));
    end
    $display("Test curves done");
    wrd(8'h90, 8'h55);
    chk({8'h0, rv}, 16'h0000);
    repeat (31) stb(3, 16'h0000);
    chk({8'h0, age}, 16'h007a);
    stb(3, 16'h0000);
    chk({8'h0, age}, 16'h0079);
    repeat (3) lookup(8'sh32);
    chk({8'h0, nv_out}, 16'h0079);
    chk(mah, 16'h004b);
    chk(16'(saves > 0), 16'h0001);
    stb(4, 16'h0070);
    chk({age, nv_out}, 16'h7070);
    $display("Test aging done");
    stb(1, 16'hff38);
    stb(1, 16'hff38);
    stb(0, 16'h0090);
    chk({14'h0, chg, learn}, 16'h0001);
    stb(0, 16'h00e0);
    stb(2, 16'h0064);
    chk({14'h0, chg, learn}, 16'h0001);
    stb(2, 16'h0064);
    chk({6'h0, chg, learn, age}, 16'h0271);
    $display("Test detection done");
    @(posedge clk_sys);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    chk(full_t, 16'h4000);
    chk({age, nv_out}, 16'h8080);
    chk({14'h0, chg, learn}, 16'h0000);
    $display("Test reset done");
    report_and_stop();
  end
endmodule
`default_nettype wire
